// ### hdl/exec_pkg.sv
// Constants for the divide, trap, halt, increment and jump execution unit
// Notes on behaviour
// - Divide splits the signed 32-bit even/odd pair by source; quotient to even.
// - Remainder goes to the odd register, sign of dividend; register must be even.
// - Zero divisor or quotient beyond 15 bits plus sign sets V and aborts.
// - Divide by zero also sets C.
// - Every opcode 104000 to 104377 is the emulator trap; low byte is free.
// - Emulator trap pushes status then PC; new PC from 30, status from 32.
// - Both trap instructions load all four flags from the vector status word.
// - I/O trap pushes status then PC; new PC from 20, status from 22.
// - Halt stops to the debugger; with memory management, user mode traps to 10.
// - With the halt trap jumper fitted, halt always traps to 10.
// - Increment word or byte adds one to the destination and writes back.
// - Increment sets V only when the old value was 077777 (old low byte 0177 for the byte form); C is kept.
// - Increment sets N on a negative result and Z on a zero result.
// - Jump with register mode 0 is illegal and traps through 4.
// - Jump in register-deferred mode goes to the address held in the register.
// - Jump and call load the effective address itself into R7.
// - Call latches target, pushes link register, copies return PC, loads target.
// - Call with register mode 0 destination traps through 4.
// - Halt, jump and call leave the four flags unchanged.
package exec_pkg;
  localparam logic [15:0] VEC_ILLEGAL   = 16'h0004;
  localparam logic [15:0] VEC_HALT      = 16'h0008;
  localparam logic [15:0] VEC_IOT       = 16'h0010;
  localparam logic [15:0] VEC_EMT       = 16'h0018;
  localparam logic [15:0] STACK_STEP    = 16'h0002;
  localparam logic [6:0]  OP_DIV_HI     = 7'h39;
  localparam logic [7:0]  OP_EMT_HI     = 8'h88;
  localparam logic [15:0] OP_IOT        = 16'h0004;
  localparam logic [15:0] OP_HALT       = 16'h0000;
  localparam logic [8:0]  OP_INC_MID    = 9'h02a;
  localparam logic [9:0]  OP_JMP_HI     = 10'h001;
  localparam logic [6:0]  OP_JSR_HI     = 7'h04;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_V        = 1;
  localparam int          FLAG_Z        = 2;
  localparam int          FLAG_N        = 3;
  localparam logic [15:0] WORD_MAX_POS  = 16'h7fff;
  localparam logic [7:0]  BYTE_MAX_POS  = 8'h7f;
  localparam logic [31:0] QUOT_MAX_POS  = 32'h00007fff;
  localparam logic [31:0] QUOT_MAX_NEG  = 32'h00008000;
  localparam logic [1:0]  REG_CTRL      = 2'h0;
  localparam logic [1:0]  REG_STAT      = 2'h1;
  localparam logic [1:0]  REG_COUNT     = 2'h2;
  localparam int          CTRL_MMU_BIT  = 0;
  localparam logic        CTRL_MMU_RST  = 1'b0;
  localparam int          STAT_VEC_LSB  = 0;
  localparam int          STAT_BUSY_BIT = 8;
  localparam int          STAT_JMPR_BIT = 9;
  localparam int          STAT_ABRT_BIT = 10;
  localparam int          STAT_HALT_BIT = 11;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_PUSH_PS = 3'b001,
    S_PUSH_PC = 3'b011,
    S_VEC_PC  = 3'b010,
    S_VEC_PS  = 3'b110,
    S_WB_ODD  = 3'b111,
    S_LINK    = 3'b101
  } exec_state_e;
endpackage : exec_pkg

// ### hdl/exec_unit.sv
// Execution unit for divide, traps, halt, increment, jump and call
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module exec_unit #(
  parameter int unsigned COUNT_W = 16
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic [15:0] src_val,
  input  wire logic [15:0] dst_val,
  input  wire logic [15:0] dst_ea,
  input  wire logic [15:0] reg_even,
  input  wire logic [15:0] reg_odd,
  input  wire logic [15:0] link_val,
  input  wire logic [15:0] pc_in,
  input  wire logic [15:0] ps_in,
  input  wire logic [15:0] sp_in,
  input  wire logic        kernel_mode,
  input  wire logic        halt_trap_jumper,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             rf_we,
  output logic      [2:0]  rf_sel,
  output logic      [15:0] rf_wdata,
  output logic             pc_we,
  output logic      [15:0] pc_out,
  output logic             ps_we,
  output logic      [15:0] ps_out,
  output logic             sp_we,
  output logic      [15:0] sp_out,
  output logic             dst_we,
  output logic      [15:0] dst_wdata,
  output logic             halt_req,
  output logic             done,
  output logic             busy,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata
);

  if (COUNT_W < 1 || COUNT_W > 16) begin : g_count_w_check
    $error("COUNT_W must lie between 1 and 16");
  end

  exec_pkg::exec_state_e state_r;
  exec_pkg::exec_state_e state_nxt;

  logic        jumper_m_r;
  logic        jumper_s_r;
  logic        ctrl_mmu_r;
  logic        halted_r;
  logic        abort_r;
  logic [7:0]  last_vec_r;
  logic [COUNT_W-1:0] count_r;

  logic [15:0] vec_r;
  logic [15:0] sp_r;
  logic [15:0] ret_pc_r;
  logic [15:0] tmp_r;
  logic [15:0] rem_r;
  logic [2:0]  link_sel_r;
  logic        jsr_r;

  logic        mem_req_nxt;
  logic        mem_we_nxt;
  logic [15:0] mem_addr_nxt;
  logic [15:0] mem_wdata_nxt;
  logic        rf_we_nxt;
  logic [2:0]  rf_sel_nxt;
  logic [15:0] rf_wdata_nxt;
  logic        pc_we_nxt;
  logic [15:0] pc_out_nxt;
  logic        ps_we_nxt;
  logic [15:0] ps_out_nxt;
  logic        sp_we_nxt;
  logic [15:0] sp_out_nxt;
  logic        dst_we_nxt;
  logic [15:0] dst_wdata_nxt;
  logic        halt_nxt;
  logic        done_nxt;
  logic        push_go;
  logic [15:0] push_data;
  logic [15:0] trap_vec;
  logic        div_abort;
  logic [15:0] reg_rdata_nxt;

  // Decode
  logic accept;
  logic is_div;
  logic is_emt;
  logic is_iot;
  logic is_halt;
  logic is_inc;
  logic is_jmp;
  logic is_jsr;
  logic dst_mode0;
  logic halt_traps;

  assign accept    = (state_r == exec_pkg::S_IDLE) && instr_valid;
  assign is_div    = instr[15:9] == exec_pkg::OP_DIV_HI;
  assign is_emt    = instr[15:8] == exec_pkg::OP_EMT_HI;
  assign is_iot    = instr == exec_pkg::OP_IOT;
  assign is_halt   = instr == exec_pkg::OP_HALT;
  assign is_inc    = instr[14:6] == exec_pkg::OP_INC_MID;
  assign is_jmp    = instr[15:6] == exec_pkg::OP_JMP_HI;
  assign is_jsr    = instr[15:9] == exec_pkg::OP_JSR_HI;
  assign dst_mode0 = instr[5:3] == 3'h0;
  // Jumper forces trap; else user mode under memory management
  assign halt_traps = jumper_s_r || (ctrl_mmu_r && !kernel_mode);

  // Signed divide on magnitudes
  logic [31:0] dvd;
  logic [31:0] dvd_mag;
  logic [15:0] dvs_mag;
  logic [15:0] dvs_safe;
  logic [31:0] q_mag;
  logic [31:0] r_mag;
  logic        q_neg;
  logic        div_dz;
  logic        div_ovf;
  logic [15:0] quot;
  logic [15:0] rem;

  assign dvd      = {reg_even, reg_odd};
  assign dvd_mag  = dvd[31] ? (~dvd + 32'h1) : dvd;
  assign dvs_mag  = src_val[15] ? (~src_val + 16'h1) : src_val;
  assign div_dz   = src_val == 16'h0000;
  assign dvs_safe = div_dz ? 16'h0001 : dvs_mag;
  assign q_mag    = dvd_mag / {16'h0000, dvs_safe};
  assign r_mag    = dvd_mag % {16'h0000, dvs_safe};
  assign q_neg    = dvd[31] ^ src_val[15];
  assign div_ovf  = !div_dz && (q_mag > (q_neg ? exec_pkg::QUOT_MAX_NEG
                                               : exec_pkg::QUOT_MAX_POS));
  assign quot     = q_neg ? (~q_mag[15:0] + 16'h1) : q_mag[15:0];
  assign rem      = dvd[31] ? (~r_mag[15:0] + 16'h1) : r_mag[15:0];

  // Increment, word or byte
  logic [15:0] inc_w;
  logic [7:0]  inc_b;
  logic [15:0] inc_res;
  logic        inc_neg;
  logic        inc_zero;
  logic        inc_ovf;

  assign inc_w    = dst_val + 16'h1;
  assign inc_b    = dst_val[7:0] + 8'h1;
  assign inc_res  = instr[15] ? {dst_val[15:8], inc_b} : inc_w;
  assign inc_neg  = instr[15] ? inc_b[7] : inc_w[15];
  assign inc_zero = instr[15] ? (inc_b == 8'h00) : (inc_w == 16'h0000);
  assign inc_ovf  = instr[15] ? (dst_val[7:0] == exec_pkg::BYTE_MAX_POS)
                              : (dst_val == exec_pkg::WORD_MAX_POS);

  // Sequencer
  always_comb begin
    state_nxt     = state_r;
    mem_req_nxt   = mem_req;
    mem_we_nxt    = mem_we;
    mem_addr_nxt  = mem_addr;
    mem_wdata_nxt = mem_wdata;
    rf_we_nxt     = 1'b0;
    rf_sel_nxt    = rf_sel;
    rf_wdata_nxt  = rf_wdata;
    pc_we_nxt     = 1'b0;
    pc_out_nxt    = pc_out;
    ps_we_nxt     = 1'b0;
    ps_out_nxt    = ps_out;
    sp_we_nxt     = 1'b0;
    sp_out_nxt    = sp_out;
    dst_we_nxt    = 1'b0;
    dst_wdata_nxt = dst_wdata;
    halt_nxt      = 1'b0;
    done_nxt      = 1'b0;
    push_go       = 1'b0;
    push_data     = ps_in;
    trap_vec      = vec_r;
    div_abort     = 1'b0;
    unique case (state_r)
      exec_pkg::S_IDLE: begin
        if (instr_valid) begin
          if (is_div) begin
            ps_out_nxt = ps_in;
            if (div_dz || div_ovf) begin
              div_abort = 1'b1;
              ps_we_nxt = 1'b1;
              ps_out_nxt[exec_pkg::FLAG_V] = 1'b1;
              ps_out_nxt[exec_pkg::FLAG_C] = div_dz;
              done_nxt = 1'b1;
            end else begin
              rf_we_nxt    = 1'b1;
              rf_sel_nxt   = instr[8:6];
              rf_wdata_nxt = quot;
              ps_out_nxt[exec_pkg::FLAG_N] = quot[15];
              ps_out_nxt[exec_pkg::FLAG_Z] = quot == 16'h0000;
              ps_out_nxt[exec_pkg::FLAG_V] = 1'b0;
              ps_out_nxt[exec_pkg::FLAG_C] = 1'b0;
              state_nxt = exec_pkg::S_WB_ODD;
            end
          end else if (is_emt) begin
            push_go  = 1'b1;
            trap_vec = exec_pkg::VEC_EMT;
          end else if (is_iot) begin
            push_go  = 1'b1;
            trap_vec = exec_pkg::VEC_IOT;
          end else if (is_halt) begin
            if (halt_traps) begin
              push_go  = 1'b1;
              trap_vec = exec_pkg::VEC_HALT;
            end else begin
              halt_nxt = 1'b1;
              done_nxt = 1'b1;
            end
          end else if (is_inc) begin
            dst_we_nxt    = 1'b1;
            dst_wdata_nxt = inc_res;
            ps_we_nxt     = 1'b1;
            ps_out_nxt    = ps_in;
            ps_out_nxt[exec_pkg::FLAG_N] = inc_neg;
            ps_out_nxt[exec_pkg::FLAG_Z] = inc_zero;
            ps_out_nxt[exec_pkg::FLAG_V] = inc_ovf;
            done_nxt = 1'b1;
          end else if (is_jmp) begin
            if (dst_mode0) begin
              push_go  = 1'b1;
              trap_vec = exec_pkg::VEC_ILLEGAL;
            end else begin
              pc_we_nxt  = 1'b1;
              pc_out_nxt = dst_ea;
              done_nxt   = 1'b1;
            end
          end else if (is_jsr) begin
            push_go = 1'b1;
            if (dst_mode0) begin
              trap_vec = exec_pkg::VEC_ILLEGAL;
            end else begin
              push_data = link_val;
            end
          end else begin
            done_nxt = 1'b1;
          end
        end
      end
      exec_pkg::S_PUSH_PS: begin
        if (mem_ack) begin
          if (jsr_r) begin
            mem_req_nxt  = 1'b0;
            sp_we_nxt    = 1'b1;
            sp_out_nxt   = sp_r - exec_pkg::STACK_STEP;
            rf_we_nxt    = 1'b1;
            rf_sel_nxt   = link_sel_r;
            rf_wdata_nxt = ret_pc_r;
            state_nxt    = exec_pkg::S_LINK;
          end else begin
            mem_addr_nxt  = sp_r - (exec_pkg::STACK_STEP << 1);
            mem_wdata_nxt = ret_pc_r;
            state_nxt     = exec_pkg::S_PUSH_PC;
          end
        end
      end
      exec_pkg::S_PUSH_PC: begin
        if (mem_ack) begin
          sp_we_nxt    = 1'b1;
          sp_out_nxt   = sp_r - (exec_pkg::STACK_STEP << 1);
          mem_we_nxt   = 1'b0;
          mem_addr_nxt = vec_r;
          state_nxt    = exec_pkg::S_VEC_PC;
        end
      end
      exec_pkg::S_VEC_PC: begin
        if (mem_ack) begin
          pc_out_nxt   = mem_rdata;
          mem_addr_nxt = vec_r + exec_pkg::STACK_STEP;
          state_nxt    = exec_pkg::S_VEC_PS;
        end
      end
      exec_pkg::S_VEC_PS: begin
        if (mem_ack) begin
          mem_req_nxt = 1'b0;
          pc_we_nxt   = 1'b1;
          ps_we_nxt   = 1'b1;
          ps_out_nxt  = mem_rdata;
          done_nxt    = 1'b1;
          state_nxt   = exec_pkg::S_IDLE;
        end
      end
      exec_pkg::S_WB_ODD: begin
        rf_we_nxt    = 1'b1;
        rf_sel_nxt   = rf_sel | 3'h1;
        rf_wdata_nxt = rem_r;
        ps_we_nxt    = 1'b1;
        done_nxt     = 1'b1;
        state_nxt    = exec_pkg::S_IDLE;
      end
      exec_pkg::S_LINK: begin
        pc_we_nxt  = 1'b1;
        pc_out_nxt = tmp_r;
        done_nxt   = 1'b1;
        state_nxt  = exec_pkg::S_IDLE;
      end
      default: begin
        mem_req_nxt = 1'b0;
        state_nxt   = exec_pkg::S_IDLE;
      end
    endcase
    if (push_go) begin
      mem_req_nxt   = 1'b1;
      mem_we_nxt    = 1'b1;
      mem_addr_nxt  = sp_in - exec_pkg::STACK_STEP;
      mem_wdata_nxt = push_data;
      state_nxt     = exec_pkg::S_PUSH_PS;
    end
  end

  // Control state and registered outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r   <= exec_pkg::S_IDLE;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= exec_pkg::WORD_RST;
      mem_wdata <= exec_pkg::WORD_RST;
      rf_we     <= 1'b0;
      rf_sel    <= 3'h0;
      rf_wdata  <= exec_pkg::WORD_RST;
      pc_we     <= 1'b0;
      pc_out    <= exec_pkg::WORD_RST;
      ps_we     <= 1'b0;
      ps_out    <= exec_pkg::WORD_RST;
      sp_we     <= 1'b0;
      sp_out    <= exec_pkg::WORD_RST;
      dst_we    <= 1'b0;
      dst_wdata <= exec_pkg::WORD_RST;
      halt_req  <= 1'b0;
      done      <= 1'b0;
      busy      <= 1'b0;
    end else if (clk_en) begin
      state_r   <= state_nxt;
      mem_req   <= mem_req_nxt;
      mem_we    <= mem_we_nxt;
      mem_addr  <= mem_addr_nxt;
      mem_wdata <= mem_wdata_nxt;
      rf_we     <= rf_we_nxt;
      rf_sel    <= rf_sel_nxt;
      rf_wdata  <= rf_wdata_nxt;
      pc_we     <= pc_we_nxt;
      pc_out    <= pc_out_nxt;
      ps_we     <= ps_we_nxt;
      ps_out    <= ps_out_nxt;
      sp_we     <= sp_we_nxt;
      sp_out    <= sp_out_nxt;
      dst_we    <= dst_we_nxt;
      dst_wdata <= dst_wdata_nxt;
      halt_req  <= halt_nxt;
      done      <= done_nxt;
      busy      <= state_nxt != exec_pkg::S_IDLE;
    end
  end

  // Operands latched at acceptance
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      vec_r      <= exec_pkg::WORD_RST;
      sp_r       <= exec_pkg::WORD_RST;
      ret_pc_r   <= exec_pkg::WORD_RST;
      tmp_r      <= exec_pkg::WORD_RST;
      rem_r      <= exec_pkg::WORD_RST;
      link_sel_r <= 3'h0;
      jsr_r      <= 1'b0;
    end else if (clk_en && accept) begin
      vec_r      <= trap_vec;
      sp_r       <= sp_in;
      ret_pc_r   <= pc_in;
      tmp_r      <= dst_ea;
      rem_r      <= rem;
      link_sel_r <= instr[8:6];
      jsr_r      <= is_jsr && !dst_mode0;
    end
  end

  // Jumper pin synchroniser
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      jumper_m_r <= 1'b0;
      jumper_s_r <= 1'b0;
    end else if (clk_en) begin
      jumper_m_r <= halt_trap_jumper;
      jumper_s_r <= jumper_m_r;
    end
  end

  // Software registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_mmu_r <= exec_pkg::CTRL_MMU_RST;
      halted_r   <= 1'b0;
      abort_r    <= 1'b0;
      last_vec_r <= 8'h00;
      count_r    <= '0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == exec_pkg::REG_CTRL) begin
        ctrl_mmu_r <= reg_wdata[exec_pkg::CTRL_MMU_BIT];
      end
      if (halt_nxt) begin
        halted_r <= 1'b1;
      end else if (reg_wr && reg_addr == exec_pkg::REG_STAT &&
                   reg_wdata[exec_pkg::STAT_HALT_BIT]) begin
        halted_r <= 1'b0;
      end
      if (clk_en && accept && is_div) begin
        abort_r <= div_abort;
      end
      if (push_go) begin
        last_vec_r <= trap_vec[7:0];
      end
      if (done_nxt) begin
        count_r <= count_r + COUNT_W'(1);
      end
    end
  end

  always_comb begin
    reg_rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        exec_pkg::REG_CTRL: begin
          reg_rdata_nxt[exec_pkg::CTRL_MMU_BIT] = ctrl_mmu_r;
        end
        exec_pkg::REG_STAT: begin
          reg_rdata_nxt[exec_pkg::STAT_VEC_LSB +: 8] = last_vec_r;
          reg_rdata_nxt[exec_pkg::STAT_BUSY_BIT] = busy;
          reg_rdata_nxt[exec_pkg::STAT_JMPR_BIT] = jumper_s_r;
          reg_rdata_nxt[exec_pkg::STAT_ABRT_BIT] = abort_r;
          reg_rdata_nxt[exec_pkg::STAT_HALT_BIT] = halted_r;
        end
        exec_pkg::REG_COUNT: begin
          reg_rdata_nxt = 16'(count_r);
        end
        default: begin
          reg_rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rdata_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_div_quot_write: assert property (clk_en && accept && is_div && !div_dz
      && !div_ovf |=> rf_we && rf_sel == $past(instr[8:6])
      && rf_wdata == $past(quot) ##1 !clk_en || rf_we)
    else $error("divide quotient not written");
  a_div_rem_odd: assert property (clk_en && state_r == exec_pkg::S_WB_ODD
      |=> rf_we && rf_sel[0] && rf_wdata == $past(rem_r) && done)
    else $error("remainder not written to odd register");
  a_div_abort_flag: assert property (clk_en && accept && is_div
      && (div_dz || div_ovf) |=> ps_we && ps_out[exec_pkg::FLAG_V]
      && !rf_we && done)
    else $error("divide abort wrong");
  a_div_zero_carry: assert property (clk_en && accept && is_div && div_dz
      |=> ps_out[exec_pkg::FLAG_C])
    else $error("divide by zero without carry");
  a_emt_vector_addr: assert property (clk_en && accept && is_emt
      |=> mem_req && mem_we && mem_wdata == $past(ps_in)
      && vec_r == exec_pkg::VEC_EMT)
    else $error("emulator trap push wrong");
  a_trap_status_load: assert property (clk_en && mem_ack
      && state_r == exec_pkg::S_VEC_PS |=> ps_we && pc_we
      && ps_out == $past(mem_rdata))
    else $error("trap status not loaded");
  a_halt_jumper_trap: assert property (clk_en && accept && is_halt
      && jumper_s_r |=> state_r == exec_pkg::S_PUSH_PS
      && vec_r == exec_pkg::VEC_HALT && !halt_req)
    else $error("halt with jumper did not trap");
  a_inc_ovf_carry: assert property (clk_en && accept && is_inc
      && !instr[15] |=> ps_out[exec_pkg::FLAG_V] == ($past(dst_val) == 16'h7fff)
      && ps_out[exec_pkg::FLAG_C] == $past(ps_in[exec_pkg::FLAG_C]))
    else $error("increment flags wrong");
  a_jmp_illegal_vec: assert property (clk_en && accept && is_jmp && dst_mode0
      |=> vec_r == exec_pkg::VEC_ILLEGAL && !pc_we)
    else $error("jump mode 0 not trapped");
  a_jmp_flags_kept: assert property (clk_en && accept && is_jmp && !dst_mode0
      |=> pc_we && pc_out == $past(dst_ea) && !ps_we)
    else $error("jump wrong");

  c_div_done: cover property (clk_en && state_r == exec_pkg::S_WB_ODD);
  c_trap_done: cover property (clk_en && state_r == exec_pkg::S_VEC_PS
      && mem_ack);
  c_call_done: cover property (clk_en && state_r == exec_pkg::S_LINK);
  c_halt_stop: cover property (halt_req);

endmodule : exec_unit
`default_nettype wire

// ### verif/mem_model.sv
// Memory partner answering the execution unit bus
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        core_clk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [256];
  logic [2:0]  wait_r;
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 16'hc300 + 16'(2 * i);
    {mem_ack, wait_r, mem_rdata} = '0;
  end
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      wait_r <= wait_r + 3'h1;
      if (wait_r >= (slow ? 3'h4 : 3'h0)) begin
        wait_r <= 3'h0;
        mem_ack <= 1'b1;
        if (mem_we)
          mem[mem_addr[8:1]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[8:1]];
      end
    end
  end
endmodule : mem_model
`default_nettype wire

// ### verif/test_divide_trap_jump_exec.sv
// Self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module test_divide_trap_jump_exec;
  logic        core_clk, reset, clk_en, instr_valid, kernel_mode, slow;
  logic        halt_trap_jumper, reg_wr, reg_rd, mem_req, mem_we, mem_ack;
  logic        rf_we, pc_we, ps_we, sp_we, dst_we, halt_req, done, busy;
  logic [1:0]  reg_addr;
  logic [2:0]  rf_sel, rr;
  logic [15:0] instr, src_val, dst_val, dst_ea, reg_even, reg_odd, link_val;
  logic [15:0] pc_in, ps_in, sp_in, mem_addr, mem_wdata, mem_rdata, res;
  logic [15:0] rf_wdata, pc_out, ps_out, sp_out, dst_wdata, reg_wdata;
  logic [15:0] reg_rdata;
  int          num_errors, checks, seed, nissue, nhalt;
  int          q_rf[$], q_pc[$], q_ps[$], q_sp[$], q_dst[$];
  longint      dv, sv, qt, rm;
  localparam logic [15:0] INC_V [4] = '{16'h7fff, 16'hffff, 16'h007f, 16'h80ff};
  exec_unit exec_unit_inst (.*);
  mem_model mem_model_inst (.*);
  always #5 core_clk = ~core_clk;
  function automatic int pop(ref int q[$]);
    return q.size() ? q.pop_front() : -1;
  endfunction : pop
  task automatic chk(input string n, input int e, input logic [18:0] g);
    checks++;
    if (g !== 19'(e)) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, 19'(e), g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge core_clk) begin
    if (rf_we) chk("rf", pop(q_rf), {rf_sel, rf_wdata});
    if (pc_we) chk("pc", pop(q_pc), pc_out);
    if (ps_we) chk("ps", pop(q_ps), ps_out);
    if (sp_we) chk("sp", pop(q_sp), sp_out);
    if (dst_we) chk("dst", pop(q_dst), dst_wdata);
    if (halt_req) nhalt++;
    if (mem_req || done) chk("busy", mem_req, busy);
  end
  task automatic prep();
    src_val <= 16'($random(seed));
    dst_val <= 16'($random(seed));
    dst_ea <= 16'($random(seed)) & 16'hfffe;
    reg_even <= 16'($random(seed));
    reg_odd <= 16'($random(seed));
    link_val <= 16'($random(seed));
    pc_in <= 16'($random(seed)) & 16'hfffe;
    ps_in <= 16'($random(seed));
    sp_in <= 16'h0180 | (16'($random(seed)) & 16'h003e);
    rr <= 3'($random(seed)) & 3'h6;
    @(posedge core_clk);
  endtask : prep
  task automatic issue(input logic [15:0] op);
    instr <= op;
    instr_valid <= 1'b1;
    nissue++;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    for (int i = 0; i < 40 && done !== 1'b1; i++)
      @(posedge core_clk);
    chk("done", 1, done);
    @(posedge core_clk);
    chk("left", 0, 19'(q_rf.size() + q_pc.size() + q_ps.size()
                       + q_sp.size() + q_dst.size()));
  endtask : issue
  task automatic trap(input logic [15:0] op, input logic [15:0] vec);
    q_sp.push_back(sp_in - 4);
    q_pc.push_back(16'hc300 + vec);
    q_ps.push_back(16'hc302 + vec);
    issue(op);
    chk("push_ps", ps_in, mem_model_inst.mem[sp_in[8:1] - 1]);
    chk("push_pc", pc_in, mem_model_inst.mem[sp_in[8:1] - 2]);
  endtask : trap
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input int e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk("reg", e, reg_rdata);
  endtask : rd
  initial begin
    {core_clk, reset, clk_en, kernel_mode, seed} = {4'h7, 32'd43422};
    {instr_valid, halt_trap_jumper, slow, reg_wr, reg_rd, reg_addr} = '0;
    {instr, src_val, dst_val, dst_ea, reg_even, reg_odd, link_val} = '0;
    {pc_in, ps_in, sp_in, reg_wdata, rr} = '0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(2'h0, 0);
    rd(2'h2, 0);
    wr(2'h3, 16'hffff);
    rd(2'h3, 0);
    $display("register test finished");
    for (int k = 0; k < 16; k++) begin
      prep();
      if (!k[1]) reg_even <= {16{k[0]}};
      if (k[1:0] == 2'h3) src_val <= 16'h0;
      @(posedge core_clk);
      dv = $signed({reg_even, reg_odd});
      sv = $signed(src_val);
      qt = sv != 0 ? dv / sv : 0;
      rm = sv != 0 ? dv % sv : 0;
      if (sv == 0 || qt > 32767 || qt < -32768) begin
        q_ps.push_back({ps_in[15:2], 1'b1, sv == 0});
      end else begin
        q_rf.push_back({rr, qt[15:0]});
        q_rf.push_back({rr | 3'h1, rm[15:0]});
        q_ps.push_back({ps_in[15:4], qt[15], qt == 0, 2'h0});
      end
      issue({exec_pkg::OP_DIV_HI, rr, 6'($random(seed))});
    end
    $display("divide test finished");
    for (int k = 0; k < 8; k++) begin
      prep();
      if (k < 4) dst_val <= INC_V[k];
      @(posedge core_clk);
      res = k[1] ? {dst_val[15:8], dst_val[7:0] + 8'h1} : dst_val + 16'h1;
      q_dst.push_back(res);
      q_ps.push_back({ps_in[15:4], k[1] ? {res[7], res[7:0] == 8'h0,
        dst_val[7:0] == 8'h7f} : {res[15], res == 16'h0,
        dst_val == 16'h7fff}, ps_in[0]});
      issue({k[1], exec_pkg::OP_INC_MID, 6'($random(seed))});
    end
    $display("increment test finished");
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      prep();
      trap({exec_pkg::OP_EMT_HI, 8'(k * 85)},
           exec_pkg::VEC_EMT);
      trap(exec_pkg::OP_IOT, exec_pkg::VEC_IOT);
      trap({exec_pkg::OP_JMP_HI, 6'(k)}, exec_pkg::VEC_ILLEGAL);
      trap({exec_pkg::OP_JSR_HI, 3'(k), 6'(k)},
           exec_pkg::VEC_ILLEGAL);
      q_pc.push_back(dst_ea);
      issue({exec_pkg::OP_JMP_HI, 3'(k + 1), 3'(k)});
      q_sp.push_back(sp_in - 2);
      q_rf.push_back({3'(k), pc_in});
      q_pc.push_back(dst_ea);
      issue({exec_pkg::OP_JSR_HI, 3'(k), 3'(k + 1), 3'h3});
      chk("link", link_val, mem_model_inst.mem[sp_in[8:1] - 1]);
    end
    $display("trap and jump test finished");
    kernel_mode <= 1'b0;
    issue(exec_pkg::OP_HALT);
    wr(2'h0, 16'h0001);
    rd(2'h0, 1);
    trap(exec_pkg::OP_HALT, exec_pkg::VEC_HALT);
    kernel_mode <= 1'b1;
    issue(exec_pkg::OP_HALT);
    chk("halts", 2, 19'(nhalt));
    kernel_mode <= 1'b0;
    trap(exec_pkg::OP_HALT, exec_pkg::VEC_HALT);
    kernel_mode <= 1'b1;
    halt_trap_jumper <= 1'b1;
    repeat (3) @(posedge core_clk);
    trap(exec_pkg::OP_HALT, exec_pkg::VEC_HALT);
    issue(16'h8900);
    rd(2'h1, 16'h0e08);
    wr(2'h1, 16'h0800);
    rd(2'h1, 16'h0608);
    rd(2'h2, nissue);
    $display("halt test finished");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end
endmodule : test_divide_trap_jump_exec
`default_nettype wire
